/* rtl/armod_map.svh */
// Constants for the result data modifier: sizes, mode codes, slot numbers and control codes.
`ifndef ARMOD_MAP_SVH
`define ARMOD_MAP_SVH

`define ARMOD_NUM_GROUPS    4'hb
`define ARMOD_SCAN_BITS     88
`define ARMOD_SCAN_IDX_W    7
`define ARMOD_ENTRIES       176
`define ARMOD_ENTRY_LAST    8'haf
`define ARMOD_MODE_STD      2'h0
`define ARMOD_MODE_FILT     2'h1
`define ARMOD_MODE_DIFF     2'h2
`define ARMOD_REF_SLOT      4'h0
`define ARMOD_FILT_SLOT_LO  4'h7
`define ARMOD_FILT_SLOT_HI  4'hf
`define ARMOD_ACC_MAX       4'h3
`define ARMOD_IIR_HALF      4'he
`define ARMOD_IIR_QUARTER   4'hf
`define ARMOD_VALUE_ZERO    16'h0000
`define ARMOD_HIST_ZERO     12'h000
`define ARMOD_DRC_ZERO      2'h0
`define ARMOD_DRC_ONE       2'h1
`define ARMOD_CTL_RESET     6'h00
`define ARMOD_SCAN_EMPTY    88'h0

`endif

/* rtl/armod_pkg.sv */
// Types shared by the scan sequencer and the result data modifier.
package armod_pkg;

    typedef struct packed {
        logic        valid;
        logic [3:0]  group;
        logic [3:0]  slot;
        logic [11:0] data;
    } armod_sample_t;

    typedef struct packed {
        logic       valid;
        logic [3:0] group;
        logic [2:0] channel;
    } armod_req_t;

    typedef struct packed {
        logic       we;
        logic [3:0] group;
        logic [3:0] slot;
        logic [1:0] mode;
        logic [3:0] rctr;
    } armod_cfg_t;

    typedef struct packed {
        logic [15:0] value;
        logic        valid_flag;
        logic [1:0]  reduction_counter_field;
    } armod_readout_t;

    typedef enum logic {
        ARMOD_SCAN_IDLE,
        ARMOD_SCAN_RUN
    } armod_scan_state_t;

endpackage

/* rtl/armod_scan.sv */
// Background scan sequencer: issues low-priority conversion requests, highest channel first.
`include "armod_map.svh"

module armod_scan (
    // Clock and reset
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    // Scan configuration
    input  wire logic [`ARMOD_SCAN_BITS-1:0] chan_enable,
    input  wire logic [`ARMOD_SCAN_BITS-1:0] chan_owned,
    input  wire logic                       scan_start,
    input  wire logic                       scan_repeat,
    // Arbitration
    input  wire logic                       high_prio_req,
    input  wire logic                       req_ready,
    output armod_pkg::armod_req_t           req,
    output logic                            scan_busy
);

    armod_pkg::armod_scan_state_t state_q;
    armod_pkg::armod_scan_state_t state_d;
    logic [`ARMOD_SCAN_BITS-1:0]  pending_q;
    logic [`ARMOD_SCAN_BITS-1:0]  pending_d;
    logic [`ARMOD_SCAN_BITS-1:0]  load_mask;
    logic [`ARMOD_SCAN_IDX_W-1:0] top_idx;
    logic [`ARMOD_SCAN_BITS-1:0]  top_bit;
    logic                         grant;
    logic                         last_grant;

    function automatic logic [`ARMOD_SCAN_IDX_W-1:0] highest(input logic [`ARMOD_SCAN_BITS-1:0] m);
        logic [`ARMOD_SCAN_IDX_W-1:0] r;
        r = '0;
        for (int i = 0; i < `ARMOD_SCAN_BITS; i++)
        begin
            if (m[i])
                r = `ARMOD_SCAN_IDX_W'(i);
        end
        return r;
    endfunction

    // Channels owned by a group-specific source are never scanned here.
    assign load_mask  = chan_enable & ~chan_owned;
    assign top_idx    = highest(pending_q);
    assign top_bit    = `ARMOD_SCAN_BITS'(1) << top_idx;
    // Background requests yield to any higher-priority source.
    assign req.valid  = (state_q == armod_pkg::ARMOD_SCAN_RUN) && (pending_q != `ARMOD_SCAN_EMPTY)
                        && !high_prio_req;
    assign req.group  = 4'(top_idx >> 3);
    assign req.channel = top_idx[2:0];
    assign grant      = req.valid && req_ready;
    assign last_grant = grant && ((pending_q & ~top_bit) == `ARMOD_SCAN_EMPTY);
    assign scan_busy  = (state_q == armod_pkg::ARMOD_SCAN_RUN);

    always_comb
    begin
        state_d   = state_q;
        pending_d = pending_q;
        unique case (state_q)
            armod_pkg::ARMOD_SCAN_IDLE:
            begin
                if (scan_start)
                begin
                    pending_d = load_mask;
                    state_d   = armod_pkg::ARMOD_SCAN_RUN;
                end
            end
            armod_pkg::ARMOD_SCAN_RUN:
            begin
                // Each granted channel leaves the sequence, so it is converted once per pass.
                if (grant)
                    pending_d = pending_q & ~top_bit;
                if (last_grant || pending_q == `ARMOD_SCAN_EMPTY)
                begin
                    if (scan_repeat)
                        pending_d = load_mask;
                    else
                        state_d = armod_pkg::ARMOD_SCAN_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            state_q   <= armod_pkg::ARMOD_SCAN_IDLE;
            pending_q <= `ARMOD_SCAN_EMPTY;
        end
        else
        begin
            state_q   <= state_d;
            pending_q <= pending_d;
        end
    end

endmodule

/* rtl/armod_top.sv */
// Result data modifier of the multi-group converter, with its background scan sequencer.
`include "armod_map.svh"

module armod_top (
    // Clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    // Background scan control
    input  wire logic [`ARMOD_SCAN_BITS-1:0] scan_chan_enable,
    input  wire logic [`ARMOD_SCAN_BITS-1:0] scan_chan_owned,
    input  wire logic                        scan_start,
    input  wire logic                        scan_repeat,
    input  wire logic                        high_prio_req,
    input  wire logic                        conv_req_ready,
    output armod_pkg::armod_req_t            conv_req,
    output logic                             scan_busy,
    // Converted samples from the converter core
    input  armod_pkg::armod_sample_t         sample_in,
    // Result control register writes
    input  armod_pkg::armod_cfg_t            cfg_in,
    // Result slot reads
    input  wire logic                        rd_en,
    input  wire logic [3:0]                  rd_group,
    input  wire logic [3:0]                  rd_slot,
    output armod_pkg::armod_readout_t        rd_data,
    output logic                             rd_ack,
    // Result event
    output logic                             result_event,
    output logic [3:0]                       result_event_group,
    output logic [3:0]                       result_event_slot
);

    ////////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic [5:0] fir_coef(input logic [3:0] code);
        logic [5:0] r;
        r = 6'h00;
        unique case (code)
            4'h0: r = {2'h2, 2'h1, 2'h0};
            4'h1: r = {2'h1, 2'h2, 2'h0};
            4'h2: r = {2'h2, 2'h0, 2'h1};
            4'h3: r = {2'h1, 2'h1, 2'h1};
            4'h4: r = {2'h1, 2'h0, 2'h2};
            4'h5: r = {2'h3, 2'h1, 2'h0};
            4'h6: r = {2'h2, 2'h2, 2'h0};
            4'h7: r = {2'h1, 2'h3, 2'h0};
            4'h8: r = {2'h3, 2'h0, 2'h1};
            4'h9: r = {2'h2, 2'h1, 2'h1};
            4'ha: r = {2'h1, 2'h2, 2'h1};
            4'hb: r = {2'h2, 2'h0, 2'h2};
            4'hc: r = {2'h1, 2'h1, 2'h2};
            4'hd: r = {2'h1, 2'h0, 2'h3};
            default: r = 6'h00;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] scale(input logic [1:0] k, input logic [11:0] v);
        return 16'(k) * {4'h0, v};
    endfunction

    function automatic logic [7:0] entry(input logic [3:0] g, input logic [3:0] s);
        return {g, s};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Scan sequencer

    armod_scan u_scan (
        .sys_clk       (sys_clk),
        .sys_rst       (sys_rst),
        .chan_enable   (scan_chan_enable),
        .chan_owned    (scan_chan_owned),
        .scan_start    (scan_start),
        .scan_repeat   (scan_repeat),
        .high_prio_req (high_prio_req),
        .req_ready     (conv_req_ready),
        .req           (conv_req),
        .scan_busy     (scan_busy)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Slot storage

    // 16-bit slots hold a 14-bit sum or filter output with room for signed differences.
    logic [15:0] res_q   [`ARMOD_ENTRIES];
    logic [11:0] hist1_q [`ARMOD_ENTRIES];
    logic [11:0] hist2_q [`ARMOD_ENTRIES];
    logic [1:0]  drc_q   [`ARMOD_ENTRIES];
    logic        vf_q    [`ARMOD_ENTRIES];
    logic [5:0]  ctl_q   [`ARMOD_ENTRIES];

    ////////////////////////////////////////////////////////////////////////////////
    // Sample path decode

    wire         s_ok     = sample_in.valid && (sample_in.group < `ARMOD_NUM_GROUPS);
    wire  [7:0]  s_idx    = entry(sample_in.group, sample_in.slot);
    wire  [7:0]  s_ref    = entry(sample_in.group, `ARMOD_REF_SLOT);
    wire  [11:0] s_x      = sample_in.data;
    wire  [1:0]  s_mode   = ctl_q[s_idx][5:4];
    wire  [3:0]  s_rctr   = ctl_q[s_idx][3:0];
    wire  [15:0] s_cur    = res_q[s_idx];
    wire  [1:0]  s_drc    = drc_q[s_idx];
    wire         filt_slot = (sample_in.slot == `ARMOD_FILT_SLOT_LO) || (sample_in.slot == `ARMOD_FILT_SLOT_HI);
    wire         is_filt  = (s_mode == `ARMOD_MODE_FILT) && filt_slot;
    wire         is_diff  = (s_mode == `ARMOD_MODE_DIFF) && (sample_in.slot != `ARMOD_REF_SLOT);
    wire         is_std   = (s_mode == `ARMOD_MODE_STD);
    // Reduction codes above 3 and illegal mode/slot pairs fall back to plain storage.
    wire  [1:0]  acc_n    = (is_std && s_rctr <= `ARMOD_ACC_MAX) ? s_rctr[1:0] : `ARMOD_DRC_ZERO;
    wire         is_iir   = is_filt && (s_rctr == `ARMOD_IIR_HALF || s_rctr == `ARMOD_IIR_QUARTER);
    wire  [5:0]  coef     = fir_coef(s_rctr);
    // Third-order FIR over the new sample and two held samples; gain is the coefficient sum.
    wire  [15:0] fir_y    = scale(coef[5:4], s_x) + scale(coef[3:2], hist1_q[s_idx])
                            + scale(coef[1:0], hist2_q[s_idx]);
    // IIR y = 2x + y/2 or 3x + y/4; both settle at four times the input.
    wire  [15:0] iir_y    = (s_rctr == `ARMOD_IIR_HALF) ? scale(2'h2, s_x) + (s_cur >> 1)
                                                        : scale(2'h3, s_x) + (s_cur >> 2);
    wire  [15:0] diff_y   = {4'h0, s_x} - res_q[s_ref];
    wire         acc_run  = (acc_n == `ARMOD_DRC_ZERO) ? 1'b0 : (s_drc != `ARMOD_DRC_ZERO);
    // Summing keeps the raw total; no averaging is done here.
    wire  [15:0] acc_y    = acc_run ? s_cur + {4'h0, s_x} : {4'h0, s_x};
    wire  [1:0]  acc_drc  = acc_run ? s_drc - `ARMOD_DRC_ONE : acc_n;

    logic [15:0] new_val;
    logic [1:0]  new_drc;
    logic        set_vf;

    always_comb
    begin
        new_val = acc_y;
        new_drc = acc_drc;
        set_vf  = (acc_drc == `ARMOD_DRC_ZERO);
        if (is_filt)
        begin
            new_val = is_iir ? iir_y : fir_y;
            new_drc = `ARMOD_DRC_ZERO;
            set_vf  = 1'b1;
        end
        else if (is_diff)
        begin
            new_val = diff_y;
            new_drc = `ARMOD_DRC_ZERO;
            set_vf  = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read path and configuration write decode

    wire         r_ok    = rd_en && (rd_group < `ARMOD_NUM_GROUPS);
    wire  [7:0]  r_idx   = entry(rd_group, rd_slot);
    wire         set_hit = s_ok && set_vf && (s_idx == r_idx);
    // A read clears the flag only once the sequence is finished; a new sample setting it wins.
    wire         rd_clr  = r_ok && (drc_q[r_idx] == `ARMOD_DRC_ZERO) && !set_hit;
    wire         c_ok    = cfg_in.we && (cfg_in.group < `ARMOD_NUM_GROUPS);
    wire  [7:0]  c_idx   = entry(cfg_in.group, cfg_in.slot);

    ////////////////////////////////////////////////////////////////////////////////
    // State update

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < `ARMOD_ENTRIES; i++)
            begin
                res_q[i]   <= `ARMOD_VALUE_ZERO;
                hist1_q[i] <= `ARMOD_HIST_ZERO;
                hist2_q[i] <= `ARMOD_HIST_ZERO;
                drc_q[i]   <= `ARMOD_DRC_ZERO;
                vf_q[i]    <= 1'b0;
                ctl_q[i]   <= `ARMOD_CTL_RESET;
            end
        end
        else
        begin
            if (c_ok)
                ctl_q[c_idx] <= {cfg_in.mode, cfg_in.rctr};
            if (rd_clr)
                vf_q[r_idx] <= 1'b0;
            if (s_ok)
            begin
                res_q[s_idx]   <= new_val;
                drc_q[s_idx]   <= new_drc;
                hist1_q[s_idx] <= s_x;
                hist2_q[s_idx] <= hist1_q[s_idx];
                // An unread flag stays set while the next sequence runs.
                if (set_vf)
                    vf_q[s_idx] <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            rd_data            <= '0;
            rd_ack             <= 1'b0;
            result_event       <= 1'b0;
            result_event_group <= 4'h0;
            result_event_slot  <= 4'h0;
        end
        else
        begin
            rd_ack             <= r_ok;
            rd_data            <= r_ok ? {res_q[r_idx], vf_q[r_idx], drc_q[r_idx]} : rd_data;
            result_event       <= s_ok && set_vf;
            result_event_group <= s_ok ? sample_in.group : result_event_group;
            result_event_slot  <= s_ok ? sample_in.slot : result_event_slot;
        end
    end

endmodule

/* test/armod_reader.sv */
// Reader model: fetches one result slot the way a CPU or DMA would.
module armod_reader (
    // Clock
    input wire logic                 sys_clk,
    // Requests from the bench
    input wire logic                 go,
    input wire logic [3:0]           go_group,
    input wire logic [3:0]           go_slot,
    // Result slot read port
    output logic                     rd_en,
    output logic [3:0]               rd_group,
    output logic [3:0]               rd_slot,
    input armod_pkg::armod_readout_t rd_data,
    input wire logic                 rd_ack,
    // Outcome
    output logic                     done,
    output logic                     acked,
    output logic                     complete,
    output armod_pkg::armod_readout_t got
);
    timeunit 1ns;
    timeprecision 1ps;
    initial
    begin
        {rd_en, rd_group, rd_slot, done, acked, complete} = '0;
        got = '0;
    end
    // The address is inverted after the pulse, so a design that samples it late reads the wrong slot.
    always @(negedge sys_clk)
    begin
        done <= 1'b0;
        if (go)
        begin
            rd_en <= 1'b1;
            rd_group <= go_group;
            rd_slot <= go_slot;
            @(negedge sys_clk);
            rd_en <= 1'b0;
            rd_group <= ~go_group;
            rd_slot <= ~go_slot;
            acked <= rd_ack;
            got <= rd_ack ? rd_data : got;
            complete <= rd_ack && rd_data.valid_flag && rd_data.reduction_counter_field == 2'h0;
            done <= 1'b1;
        end
    end
endmodule

/* test/armod_top_sva_sva.sv */
// Port-level assertions for the result data modifier and its scan sequencer.
`include "armod_map.svh"

module armod_top_sva (
    // Clock and reset
    input wire logic                        sys_clk,
    input wire logic                        sys_rst,
    // Scan side
    input wire logic [`ARMOD_SCAN_BITS-1:0] scan_chan_enable,
    input wire logic [`ARMOD_SCAN_BITS-1:0] scan_chan_owned,
    input wire logic                        scan_start,
    input wire logic                        scan_repeat,
    input wire logic                        high_prio_req,
    input wire logic                        conv_req_ready,
    input armod_pkg::armod_req_t            conv_req,
    input wire logic                        scan_busy,
    // Samples, reads and events
    input armod_pkg::armod_sample_t         sample_in,
    input wire logic                        rd_en,
    input wire logic [3:0]                  rd_group,
    input armod_pkg::armod_readout_t        rd_data,
    input wire logic                        rd_ack,
    input wire logic                        result_event,
    input wire logic [3:0]                  result_event_group,
    input wire logic [3:0]                  result_event_slot
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic [6:0] req_idx;
    assign req_idx = {conv_req.group, 3'h0} + {4'h0, conv_req.channel};
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    ////////////////////////////////
    a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !conv_req.valid && !scan_busy && !rd_ack
        && !result_event && rd_data == '0) else $error("outputs not quiet after reset");
    a_read_ack: assert property (rd_en && rd_group < 4'hb |=> rd_ack) else $error("read not acknowledged");
    a_ack_cause: assert property (rd_ack |-> $past(rd_en) && $past(rd_group) < 4'hb)
        else $error("acknowledge without a legal read");
    a_prio_yield: assert property (high_prio_req |-> !conv_req.valid) else $error("scan did not yield");
    a_req_holds: assert property (conv_req.valid && !conv_req_ready |=> high_prio_req
        || (conv_req.valid && $stable(req_idx))) else $error("request dropped before grant");
    a_order_down: assert property ((conv_req.valid && conv_req_ready && !scan_repeat) ##1 conv_req.valid
        |-> req_idx < $past(req_idx)) else $error("scan order not descending");
    a_skip_owned: assert property (conv_req.valid |-> scan_chan_enable[req_idx] && !scan_chan_owned[req_idx])
        else $error("request for a disabled or owned channel");
    a_start_req: assert property (scan_start && !scan_busy && |(scan_chan_enable & ~scan_chan_owned)
        ##1 !high_prio_req |-> conv_req.valid && scan_busy) else $error("scan did not start");
    a_event_cause: assert property (result_event |-> $past(sample_in.valid) && $past(sample_in.group) < 4'hb
        && result_event_group == $past(sample_in.group) && result_event_slot == $past(sample_in.slot))
        else $error("result event without its sample");
    a_group_skip: assert property (sample_in.valid && sample_in.group >= 4'hb |=> !result_event)
        else $error("sample of a missing group accepted");
    c_grant: cover property (conv_req.valid && conv_req_ready);
    c_event: cover property (result_event);
    c_done: cover property (rd_ack && rd_data.valid_flag && rd_data.reduction_counter_field == 2'h0);
endmodule

bind armod_top armod_top_sva u_sva (.sys_clk, .sys_rst, .scan_chan_enable, .scan_chan_owned, .scan_start,
    .scan_repeat, .high_prio_req, .conv_req_ready, .conv_req, .scan_busy, .sample_in, .rd_en, .rd_group,
    .rd_data, .rd_ack, .result_event, .result_event_group, .result_event_slot);

/* test/tb_top.sv */
// Self-checking bench for the result data modifier with a behavioural slot model.
`include "armod_map.svh"

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0, sys_rst = 1'b1, scan_start = 1'b0, scan_repeat = 1'b0;
    logic high_prio_req = 1'b0, conv_req_ready = 1'b0, go = 1'b0;
    logic [`ARMOD_SCAN_BITS-1:0] scan_chan_enable = '0, scan_chan_owned = '0;
    logic rd_en, rd_ack, scan_busy, result_event, done, acked, complete;
    logic [3:0] rd_group, rd_slot, result_event_group, result_event_slot, go_group = 4'h0, go_slot = 4'h0;
    armod_pkg::armod_req_t conv_req;
    armod_pkg::armod_sample_t sample_in = '0;
    armod_pkg::armod_cfg_t cfg_in = '0;
    armod_pkg::armod_readout_t rd_data, got;
    int n_errors = 0, compares = 0;
    int mv[256], mdrc[256], mfl[256], h1[256], h2[256], mmode[256], mr[256], got_q[$], exp_q[$];
    logic [31:0] seed = 32'he6ee3dfa, rv;
    localparam logic [5:0] FIR [14] = '{6'h24, 6'h18, 6'h21, 6'h15, 6'h12, 6'h34, 6'h28,
                                        6'h1c, 6'h31, 6'h25, 6'h19, 6'h22, 6'h16, 6'h13};
    always #5 sys_clk = ~sys_clk;
    armod_top uut (.sys_clk, .sys_rst, .scan_chan_enable, .scan_chan_owned, .scan_start, .scan_repeat,
        .high_prio_req, .conv_req_ready, .conv_req, .scan_busy, .sample_in, .cfg_in, .rd_en, .rd_group,
        .rd_slot, .rd_data, .rd_ack, .result_event, .result_event_group, .result_event_slot);
    armod_reader u_reader (.sys_clk, .go, .go_group, .go_slot, .rd_en, .rd_group, .rd_slot, .rd_data,
        .rd_ack, .done, .acked, .complete, .got);
    ////////////////////////////////
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic finish_test();
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic cfg(input logic [3:0] g, input logic [3:0] s, input logic [1:0] m, input logic [3:0] r);
        mmode[g * 16 + s] = m;
        mr[g * 16 + s] = r;
        @(negedge sys_clk) cfg_in <= '{1'b1, g, s, m, r};
        @(negedge sys_clk) cfg_in.we <= 1'b0;
    endtask
    task automatic smp(input logic [3:0] g, input logic [3:0] s, input logic [11:0] x);
        int k, ev;
        k = g * 16 + s;
        ev = (g < 11);
        if (g < 11)
        begin
            if (mmode[k] == 1 && (s == 7 || s == 15))
            begin
                if (mr[k] < 14)
                    mv[k] = FIR[mr[k]][5:4] * x + FIR[mr[k]][3:2] * h1[k] + FIR[mr[k]][1:0] * h2[k];
                else
                    mv[k] = (mr[k] == 14) ? 2 * x + mv[k] / 2 : 3 * x + mv[k] / 4;
                {mfl[k], mdrc[k]} = {32'h1, 32'h0};
            end
            else if (mmode[k] == 2 && s != 0)
                {mv[k], mfl[k], mdrc[k]} = {(x - mv[g * 16]) & 32'h0000ffff, 32'h1, 32'h0};
            else if (mmode[k] == 0 && mr[k] >= 1 && mr[k] <= 3 && mdrc[k] == 0)
                {mv[k], mdrc[k], ev} = {32'(x), mr[k], 32'h0};
            else if (mmode[k] == 0 && mr[k] >= 1 && mr[k] <= 3)
            begin
                ev = (mdrc[k] == 1);
                {mv[k], mdrc[k], mfl[k]} = {mv[k] + x, mdrc[k] - 1, 32'(mfl[k] || ev)};
            end
            else
                {mv[k], mfl[k], mdrc[k]} = {32'(x), 32'h1, 32'h0};
            {h2[k], h1[k]} = {h1[k], 32'(x)};
        end
        @(negedge sys_clk) sample_in <= '{1'b1, g, s, x};
        @(negedge sys_clk) sample_in.valid <= 1'b0;
        check("event", result_event, ev);
        if (ev)
            check("event slot", {result_event_group, result_event_slot}, {g, s});
    endtask
    task automatic rd(input logic [3:0] g, input logic [3:0] s);
        int k;
        k = g * 16 + s;
        @(negedge sys_clk);
        {go_group, go_slot, go} <= {g, s, 1'b1};
        @(negedge sys_clk);
        go <= 1'b0;
        repeat (4) @(negedge sys_clk) if (done === 1'b1) break;
        check("ack", acked, g < 11);
        if (g < 11)
        begin
            check("value", got.value, mv[k]);
            check("flag", got.valid_flag, mfl[k]);
            check("count", got.reduction_counter_field, mdrc[k]);
            check("complete", complete, mfl[k] == 1 && mdrc[k] == 0);
            mfl[k] = (mdrc[k] == 0) ? 0 : mfl[k];
        end
    endtask
    task automatic scan(input logic rep, input int n);
        got_q.delete();
        @(negedge sys_clk);
        {scan_repeat, scan_start} <= {rep, 1'b1};
        @(negedge sys_clk);
        scan_start <= 1'b0;
        for (int i = 0; i < 2000 && got_q.size() < n; i++) @(negedge sys_clk);
        scan_repeat <= 1'b0;
        for (int i = 0; i < 500 && scan_busy !== 1'b0; i++) @(negedge sys_clk);
        check("busy", scan_busy, 0);
        for (int i = 0; i < n; i++) check("order", got_q[i], exp_q[i % exp_q.size()]);
        if (!rep) check("grants", got_q.size(), n);
        else check("grants", got_q.size() >= n, 1);
    endtask
    ////////////////////////////////
    always @(negedge sys_clk)
    begin
        rv = rnd();
        conv_req_ready <= rv[0] | rv[1];
        high_prio_req <= rv[4:2] == 3'h0;
    end
    always @(posedge sys_clk)
        if (!sys_rst && conv_req.valid === 1'b1 && conv_req_ready)
            got_q.push_back(int'(conv_req.group) * 8 + int'(conv_req.channel));
    initial
    begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial
    begin
        logic [3:0] s;
        repeat (12) @(negedge sys_clk);
        sys_rst <= 1'b0;
        rd(4'h2, 4'h3);
        for (int r = 0; r < 4; r++)
        begin
            cfg(4'h2, 4'(r * 5), 2'h0, 4'(r));
            repeat (r + 1) smp(4'h2, 4'(r * 5), 12'(rnd()));
            rd(4'h2, 4'(r * 5));
        end
        repeat (5) smp(4'h2, 4'hf, 12'(rnd()));
        rd(4'h2, 4'hf);
        repeat (3) smp(4'h2, 4'hf, 12'(rnd()));
        rd(4'h2, 4'hf);
        for (int r = 0; r < 16; r++)
        begin
            s = (r < 14) ? 4'h7 : 4'hf;
            cfg(4'ha, s, 2'h1, 4'(r));
            repeat (3) smp(4'ha, s, 12'(rnd()));
            rd(4'ha, s);
        end
        cfg(4'h1, 4'h5, 2'h1, 4'h0);
        smp(4'h1, 4'h5, 12'(rnd()));
        rd(4'h1, 4'h5);
        cfg(4'h3, 4'h0, 2'h2, 4'h0);
        smp(4'h3, 4'h0, 12'(rnd()));
        rd(4'h3, 4'h0);
        cfg(4'h3, 4'h9, 2'h2, 4'h0);
        repeat (2) smp(4'h3, 4'h9, 12'(rnd()));
        rd(4'h3, 4'h9);
        smp(4'hb, 4'h9, 12'(rnd()));
        rd(4'hb, 4'h9);
        rd(4'h3, 4'h9);
        scan_chan_enable = (88'h1 << 87) | (88'h3 << 40) | 88'h21;
        scan_chan_owned = 88'h1 << 40;
        for (int i = 87; i >= 0; i--) if (scan_chan_enable[i] && !scan_chan_owned[i]) exp_q.push_back(i);
        scan(1'b0, exp_q.size());
        scan(1'b1, 2 * exp_q.size());
        finish_test();
    end
endmodule
